// ---- verilog/hprc_pkg.sv ----
/*
 * hprc_pkg: constants, register map, state codes and the carrier struct
 * for the host power and reset control block.
 * Assumes a 40 MHz block clock and synchronous key and sense inputs.
 */
package hprc_pkg;
	// clock and tick base
	localparam int CLK_HZ = 40000000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	// documented times in milliseconds
	localparam int ON_HOLD_MS = 250;
	localparam int OFF_HOLD_MS = 4000;
	localparam int RST_HOLD_MS = 4000;
	localparam int RST_PULSE_MS = 1000;
	localparam int EXT_MS = 5000;
	localparam int PULSE_DEF_MS = 1000;
	// tick counts: least times round up
	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] ON_HOLD_TICKS = CNT_W'((ON_HOLD_MS + TICK_MS - 1) / TICK_MS);
	localparam logic [CNT_W-1:0] OFF_HOLD_TICKS = CNT_W'((OFF_HOLD_MS + TICK_MS - 1) / TICK_MS);
	localparam logic [CNT_W-1:0] RST_HOLD_TICKS = CNT_W'((RST_HOLD_MS + TICK_MS - 1) / TICK_MS);
	localparam logic [CNT_W-1:0] RST_PULSE_TICKS = CNT_W'((RST_PULSE_MS + TICK_MS - 1) / TICK_MS);
	localparam logic [CNT_W-1:0] EXT_TICKS = CNT_W'(EXT_MS / TICK_MS);
	// register port
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] REG_CFG = 4'h0;
	localparam logic [ADDR_W-1:0] REG_PULSE = 4'h1;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;
	localparam int CFG_W = 6;
	localparam logic [DATA_W-1:0] PULSE_RESET = DATA_W'(PULSE_DEF_MS / TICK_MS);
	// configuration carrier, lsb first in the register is on_en
	typedef struct packed {
		logic rst_invert; // reset line drive level
		logic pwr_invert; // power line drive level
		logic blank_en; // blank display while host off
		logic rst_en; // hard reset by key
		logic off_en; // hard power off by key
		logic on_en; // power on by key
	} hprc_cfg_s;
	localparam hprc_cfg_s CFG_RESET = 6'h00;
	// sequencer states
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_ON_HOLD = 4'h1,
		S_OFF_HOLD = 4'h2,
		S_RST_HOLD = 4'h3,
		S_ON_PULSE = 4'h4,
		S_OFF_PULSE = 4'h5,
		S_OFF_EXT = 4'h6,
		S_RST_PULSE = 4'h7,
		S_RESTART = 4'h8,
		S_WAIT_REL = 4'h9
	} hprc_state_e;
endpackage : hprc_pkg

// ---- verilog/hprc_tick_timer.sv ----
/*
 * hprc_tick_timer: elapsed time counter in ticks, restarted by clr_i.
 * Assumes clr_i is asserted in the cycle before the interval starts.
 */
`timescale 1ns/10ps
module hprc_tick_timer #(
	parameter int TICK_CYCLES = hprc_pkg::TICK_CYCLES,
	parameter int CNT_W = hprc_pkg::CNT_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clr_i,
	output logic [CNT_W-1:0] cnt_o
);
	localparam int PRE_W = $clog2(TICK_CYCLES + 1);
	// refuse settings the counters cannot serve
	if (TICK_CYCLES < 1 || CNT_W < 2) begin : g_chk
		$error("hprc_tick_timer: bad parameters");
	end
	logic [PRE_W-1:0] pre_r; // cycles inside current tick
	logic [CNT_W-1:0] cnt_r; // whole ticks elapsed
	wire tick = (pre_r == PRE_W'(TICK_CYCLES - 1));
	wire sat = &cnt_r;
	// prescaler restarts with the interval so holds time from the press
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pre_r <= '0;
			cnt_r <= '0;
		end else if (clr_i) begin
			pre_r <= '0;
			cnt_r <= '0;
		end else begin
			pre_r <= tick ? '0 : pre_r + PRE_W'(1);
			// saturate rather than wrap, so a long hold never looks short
			if (tick && !sat) begin
				cnt_r <= cnt_r + CNT_W'(1);
			end
		end
	end
	assign cnt_o = cnt_r;
endmodule : hprc_tick_timer

// ---- verilog/hprc_top.sv ----
/*
 * hprc_top: key driven host power on, hard power off and hard reset,
 * watchdog reset sharing, and display blanking while the host is off.
 * Assumes synchronous, debounced key inputs (high = pressed), a
 * power sense input high while the host is on, and an outside wire
 * that resolves each line from its output and output enable.
 */
`timescale 1ns/10ps
module hprc_top #(
	parameter int TICK_CYCLES = hprc_pkg::TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [hprc_pkg::ADDR_W-1:0] addr_i,
	input wire logic [hprc_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [hprc_pkg::DATA_W-1:0] rdata_o,
	// host sense, keys, watchdog
	input wire logic pwr_sense_i,
	input wire logic key_confirm_i,
	input wire logic key_cancel_i,
	input wire logic wdog_req_i,
	// host power switch line
	input wire logic pwr_sw_i,
	output logic pwr_sw_o,
	output logic pwr_sw_oe_o,
	// host reset switch line
	input wire logic rst_sw_i,
	output logic rst_sw_o,
	output logic rst_sw_oe_o,
	// module side
	output logic disp_blank_o,
	output logic self_restart_o
);
	localparam int CW = hprc_pkg::CNT_W;
	localparam int DW = hprc_pkg::DATA_W;

	// state and registers
	hprc_pkg::hprc_state_e state_r, state_nxt; // sequencer state
	hprc_pkg::hprc_cfg_s cfg_r; // enables and polarities
	logic [DW-1:0] pulse_r; // power pulse width in ticks
	logic wdog_pend_r; // watchdog reset waiting for the line
	logic rst_by_wdog_r; // current reset pulse came from watchdog
	logic pwr_oe_r, pwr_lvl_r, rst_oe_r, rst_lvl_r;
	logic blank_r, restart_r;
	logic [DW-1:0] rdata_r;
	logic [CW-1:0] elapsed; // ticks spent in this state
	logic [CW-1:0] target; // ticks this state waits for

	// one shared timer, restarted on every state change
	wire state_chg = (state_nxt != state_r);
	hprc_tick_timer #(
		.TICK_CYCLES(TICK_CYCLES),
		.CNT_W(CW)
	) u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(state_chg),
		.cnt_o(elapsed)
	);

	// register decode
	wire wr_cfg = wr_i && (addr_i == hprc_pkg::REG_CFG);
	wire wr_pulse = wr_i && (addr_i == hprc_pkg::REG_PULSE);
	wire [DW-1:0] status = {state_r, blank_r, rst_oe_r, pwr_oe_r, pwr_sense_i};
	wire [DW-1:0] rd_mux =
		(addr_i == hprc_pkg::REG_CFG) ? DW'(cfg_r) :
		(addr_i == hprc_pkg::REG_PULSE) ? pulse_r :
		(addr_i == hprc_pkg::REG_STATUS) ? status : '0;

	// per-state wait length; pulse width zero is treated as one tick
	wire [CW-1:0] pulse_t = (pulse_r == '0) ? CW'(1) : CW'(pulse_r);
	always_comb begin
		unique case (state_r)
			hprc_pkg::S_ON_HOLD: target = hprc_pkg::ON_HOLD_TICKS;
			hprc_pkg::S_OFF_HOLD: target = hprc_pkg::OFF_HOLD_TICKS;
			hprc_pkg::S_RST_HOLD: target = hprc_pkg::RST_HOLD_TICKS;
			hprc_pkg::S_ON_PULSE: target = pulse_t;
			hprc_pkg::S_OFF_PULSE: target = pulse_t;
			hprc_pkg::S_OFF_EXT: target = hprc_pkg::EXT_TICKS;
			hprc_pkg::S_RST_PULSE: target = hprc_pkg::RST_PULSE_TICKS;
			default: target = '1;
		endcase
	end
	wire done = (elapsed >= target);
	wire any_key = key_confirm_i || key_cancel_i;
	// watchdog may take the line whenever no power pulse, reset pulse or restart step is running
	wire wdog_take = wdog_pend_r && (state_r != hprc_pkg::S_ON_PULSE)
		&& (state_r != hprc_pkg::S_OFF_PULSE) && (state_r != hprc_pkg::S_OFF_EXT)
		&& (state_r != hprc_pkg::S_RST_PULSE) && (state_r != hprc_pkg::S_RESTART);

	// sequencer next state
	always_comb begin
		state_nxt = state_r;
		if (wdog_take) begin
			state_nxt = hprc_pkg::S_RST_PULSE;
		end else begin
			unique case (state_r)
				hprc_pkg::S_IDLE: begin
					if (key_confirm_i && !pwr_sense_i && cfg_r.on_en) begin
						state_nxt = hprc_pkg::S_ON_HOLD;
					end else if (key_cancel_i && pwr_sense_i && cfg_r.off_en) begin
						state_nxt = hprc_pkg::S_OFF_HOLD;
					end else if (key_confirm_i && pwr_sense_i && cfg_r.rst_en) begin
						state_nxt = hprc_pkg::S_RST_HOLD;
					end
				end
				// a release or a change of host state drops the action
				hprc_pkg::S_ON_HOLD: begin
					if (!key_confirm_i || pwr_sense_i || !cfg_r.on_en) begin
						state_nxt = hprc_pkg::S_IDLE;
					end else if (done) begin
						state_nxt = hprc_pkg::S_ON_PULSE;
					end
				end
				hprc_pkg::S_OFF_HOLD: begin
					if (!key_cancel_i || !pwr_sense_i || !cfg_r.off_en) begin
						state_nxt = hprc_pkg::S_IDLE;
					end else if (done) begin
						state_nxt = hprc_pkg::S_OFF_PULSE;
					end
				end
				hprc_pkg::S_RST_HOLD: begin
					if (!key_confirm_i || !pwr_sense_i || !cfg_r.rst_en) begin
						state_nxt = hprc_pkg::S_IDLE;
					end else if (done) begin
						state_nxt = hprc_pkg::S_RST_PULSE;
					end
				end
				hprc_pkg::S_ON_PULSE: begin
					if (done) begin
						state_nxt = hprc_pkg::S_WAIT_REL;
					end
				end
				hprc_pkg::S_OFF_PULSE: begin
					if (done) begin
						state_nxt = key_cancel_i ? hprc_pkg::S_OFF_EXT
							: hprc_pkg::S_WAIT_REL;
					end
				end
				hprc_pkg::S_OFF_EXT: begin
					if (!key_cancel_i || done) begin
						state_nxt = hprc_pkg::S_WAIT_REL;
					end
				end
				hprc_pkg::S_RST_PULSE: begin
					if (done) begin
						state_nxt = rst_by_wdog_r ? hprc_pkg::S_IDLE
							: hprc_pkg::S_RESTART;
					end
				end
				hprc_pkg::S_RESTART: state_nxt = hprc_pkg::S_WAIT_REL;
				// keys must be let go before a new hold can start
				hprc_pkg::S_WAIT_REL: begin
					if (!any_key) begin
						state_nxt = hprc_pkg::S_IDLE;
					end
				end
				default: state_nxt = hprc_pkg::S_IDLE;
			endcase
		end
	end

	// line drive decode from the next state, so outputs align with state_r
	wire pwr_drv_nxt = (state_nxt == hprc_pkg::S_ON_PULSE)
		|| (state_nxt == hprc_pkg::S_OFF_PULSE) || (state_nxt == hprc_pkg::S_OFF_EXT);
	wire rst_drv_nxt = (state_nxt == hprc_pkg::S_RST_PULSE);
	wire restart_nxt = (state_nxt == hprc_pkg::S_RESTART);
	// blanking gates the display only; fan power has no path through here
	wire blank_nxt = cfg_r.blank_en && !pwr_sense_i;

	// configuration registers, written only by software
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_r <= hprc_pkg::CFG_RESET;
			pulse_r <= hprc_pkg::PULSE_RESET;
		end else begin
			if (wr_cfg) begin
				cfg_r <= hprc_pkg::hprc_cfg_s'(wdata_i[hprc_pkg::CFG_W-1:0]);
			end
			if (wr_pulse) begin
				pulse_r <= wdata_i;
			end
		end
	end

	// watchdog request latch: a new request wins over the take
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wdog_pend_r <= 1'b0;
			rst_by_wdog_r <= 1'b0;
		end else begin
			wdog_pend_r <= wdog_req_i || (wdog_pend_r && !wdog_take);
			if (wdog_take) begin
				rst_by_wdog_r <= 1'b1;
			end else if (state_r == hprc_pkg::S_IDLE) begin
				rst_by_wdog_r <= 1'b0;
			end
		end
	end

	// state, pin drivers and module outputs
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= hprc_pkg::S_IDLE;
			pwr_oe_r <= 1'b0;
			pwr_lvl_r <= 1'b0;
			rst_oe_r <= 1'b0;
			rst_lvl_r <= 1'b0;
			blank_r <= 1'b0;
			restart_r <= 1'b0;
			rdata_r <= '0;
		end else begin
			state_r <= state_nxt;
			pwr_oe_r <= pwr_drv_nxt;
			pwr_lvl_r <= cfg_r.pwr_invert;
			rst_oe_r <= rst_drv_nxt;
			rst_lvl_r <= cfg_r.rst_invert;
			blank_r <= blank_nxt;
			restart_r <= restart_nxt;
			rdata_r <= rd_i ? rd_mux : '0;
		end
	end

	assign pwr_sw_o = pwr_lvl_r;
	assign pwr_sw_oe_o = pwr_oe_r;
	assign rst_sw_o = rst_lvl_r;
	assign rst_sw_oe_o = rst_oe_r;
	assign disp_blank_o = blank_r;
	assign self_restart_o = restart_r;
	assign rdata_o = rdata_r;

	// line read-backs are not needed by the sequencer
	wire unused_ok = pwr_sw_i ^ rst_sw_i;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_pwr_drive_only: assert property (
		pwr_sw_oe_o |-> (state_r == hprc_pkg::S_ON_PULSE
			|| state_r == hprc_pkg::S_OFF_PULSE || state_r == hprc_pkg::S_OFF_EXT))
		else $error("power line driven outside a power pulse");
	a_pwr_level: assert property (
		pwr_sw_oe_o |-> (pwr_sw_o == $past(cfg_r.pwr_invert)))
		else $error("power line driven at wrong level");
	a_rst_level: assert property (
		rst_sw_oe_o |-> (rst_sw_o == $past(cfg_r.rst_invert))
			&& state_r == hprc_pkg::S_RST_PULSE)
		else $error("reset line driven wrongly");
	a_on_start: assert property (
		$rose(pwr_sw_oe_o) |-> $past(cfg_r.on_en && !pwr_sense_i && key_confirm_i)
			|| $past(cfg_r.off_en && pwr_sense_i && key_cancel_i))
		else $error("power pulse without enabled key hold");
	a_ext_ends: assert property (
		(state_r == hprc_pkg::S_OFF_EXT && !key_cancel_i && !wdog_take)
			|=> !pwr_sw_oe_o)
		else $error("off extension outlived cancel key");
	a_restart_after: assert property (
		$rose(self_restart_o) |-> $past(state_r == hprc_pkg::S_RST_PULSE)
			&& $past(rst_sw_oe_o) && !rst_sw_oe_o ##1 !self_restart_o)
		else $error("self restart not right after reset pulse");
	a_blank_follow: assert property (
		(cfg_r.blank_en && !pwr_sense_i) ##1 (cfg_r.blank_en && !pwr_sense_i)
			|-> disp_blank_o)
		else $error("display not blanked while host off");
	a_hold_cancel: assert property (
		(state_r == hprc_pkg::S_ON_HOLD && !key_confirm_i && !wdog_take)
			|=> state_r == hprc_pkg::S_IDLE ##1 !pwr_sw_oe_o)
		else $error("early release did not cancel power on");
	a_wdog_served: assert property (
		$rose(wdog_pend_r) && state_r == hprc_pkg::S_IDLE && !rst_sw_oe_o
			|=> rst_sw_oe_o)
		else $error("watchdog request not driven onto reset line");
	a_rd_unmapped: assert property (
		(rd_i && addr_i > hprc_pkg::REG_STATUS) |=> rdata_o == '0)
		else $error("unmapped read not zero");
endmodule : hprc_top

// ---- verif/hprc_host_model.sv ----
/*
 * hprc_host_model: host board power and reset switch inputs, with
 * pull-ups, that time every pulse the block drives onto either line.
 * Assumes the block's line levels and output enables as inputs.
 */
`timescale 1ns/10ps
module hprc_host_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pwr_sw_o,
	input wire logic pwr_sw_oe_o,
	input wire logic rst_sw_o,
	input wire logic rst_sw_oe_o,
	output logic pwr_line_o,
	output logic rst_line_o,
	output logic done_o,
	output logic line_o,
	output logic level_o,
	output logic [31:0] len_o
);
	logic [1:0] oe_w; // enables, index 1 is the reset line
	logic [1:0] wire_w; // resolved line levels
	logic [31:0] cnt_r [2]; // driven cycles so far
	logic [1:0] lvl_r; // level seen in the first driven cycle
	// a floating line reads high through the board pull-up
	assign pwr_line_o = pwr_sw_oe_o ? pwr_sw_o : 1'b1;
	assign rst_line_o = rst_sw_oe_o ? rst_sw_o : 1'b1;
	assign oe_w = {rst_sw_oe_o, pwr_sw_oe_o};
	assign wire_w = {rst_line_o, pwr_line_o};
	// report each pulse once its enable drops
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r[0] <= '0;
			cnt_r[1] <= '0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			for (int i = 0; i < 2; i++) begin
				if (oe_w[i]) begin
					cnt_r[i] <= cnt_r[i] + 1;
				end else if (cnt_r[i] != 0) begin
					done_o <= 1'b1;
					line_o <= i[0];
					level_o <= lvl_r[i];
					len_o <= cnt_r[i];
					cnt_r[i] <= '0;
				end
				if (oe_w[i] && cnt_r[i] == 0) begin
					lvl_r[i] <= wire_w[i];
				end
			end
		end
	end
endmodule : hprc_host_model

// ---- verif/test_hprc_top.sv ----
/*
 * test_hprc_top: self-checking bench for the host power and reset block.
 * Assumes a shortened tick of four clocks and the host model beside it.
 */
`timescale 1ns/10ps
module test_hprc_top;
	localparam int TC = 4; // clocks per tick, kept short for run time
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic pwr_sense_i = 1'b0;
	logic key_confirm_i = 1'b0;
	logic key_cancel_i = 1'b0;
	logic wdog_req_i = 1'b0;
	logic pwr_line, rst_line, pwr_sw_o, pwr_sw_oe_o, rst_sw_o, rst_sw_oe_o;
	logic disp_blank_o, self_restart_o, done, line, level;
	logic [31:0] len;
	logic rd_seen = 1'b0; // a read was taken last edge
	logic [7:0] exp_r_q[$]; // expected read data, oldest first
	logic [33:0] exp_p_q[$]; // expected pulses: line, level, cycles
	logic [33:0] e;
	int num_errors = 0;
	int checks_done = 0;
	int restarts = 0;
	int seed = 41;
	int r0;
	logic [7:0] pw; // power pulse width in ticks
	logic [1:0] pol; // reset and power drive levels
	always #12.5 clk_i = ~clk_i;
	hprc_top #(.TICK_CYCLES(TC)) DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.pwr_sense_i(pwr_sense_i), .key_confirm_i(key_confirm_i),
		.key_cancel_i(key_cancel_i), .wdog_req_i(wdog_req_i), .pwr_sw_i(pwr_line),
		.pwr_sw_o(pwr_sw_o), .pwr_sw_oe_o(pwr_sw_oe_o), .rst_sw_i(rst_line),
		.rst_sw_o(rst_sw_o), .rst_sw_oe_o(rst_sw_oe_o), .disp_blank_o(disp_blank_o),
		.self_restart_o(self_restart_o));
	// the board never drives either line itself; its pull-ups hold an undriven line high
	hprc_host_model host (.clk_i(clk_i), .rst_i(rst_i), .pwr_sw_o(pwr_sw_o),
		.pwr_sw_oe_o(pwr_sw_oe_o), .rst_sw_o(rst_sw_o), .rst_sw_oe_o(rst_sw_oe_o),
		.pwr_line_o(pwr_line), .rst_line_o(rst_line), .done_o(done), .line_o(line),
		.level_o(level), .len_o(len));
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (exp !== got) begin
			num_errors++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : check
	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test
	// one-cycle register strobes, launched just after an edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] x);
		exp_r_q.push_back(x);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
	endtask : rd
	// press one key for a whole number of ticks: 0 confirm, 1 cancel
	task automatic hold(input int key, input int ticks);
		@(posedge clk_i);
		if (key == 0) key_confirm_i <= 1'b1;
		else key_cancel_i <= 1'b1;
		repeat (ticks * TC) @(posedge clk_i);
		key_confirm_i <= 1'b0;
		key_cancel_i <= 1'b0;
	endtask : hold
	task automatic expp(input logic ln, input logic lv, input int ticks);
		exp_p_q.push_back({ln, lv, 32'(ticks * TC)});
	endtask : expp
	// bounded wait until every expected pulse has been seen
	task automatic settle();
		int n = 0;
		while (exp_p_q.size() != 0 && n < 20000) begin
			@(posedge clk_i);
			n++;
		end
		repeat (20) @(posedge clk_i);
		check("pending pulses", 0, exp_p_q.size());
	endtask : settle
	// result watcher: reads, pulses and restart requests
	always @(posedge clk_i) begin
		rd_seen <= rd_i;
		if (self_restart_o === 1'b1) restarts++;
		if (rd_seen) begin
			if (exp_r_q.size() == 0) check("read queue", 1, 0);
			else check("read data", exp_r_q.pop_front(), rdata_o);
		end
		if (done === 1'b1) begin
			if (exp_p_q.size() == 0) begin
				check("unexpected pulse", 0, 1);
			end else begin
				e = exp_p_q.pop_front();
				check("pulse line", e[33], line);
				check("pulse level", e[32], level);
				// a tick boundary may shift the edges by part of a tick
				check("pulse len", e[31:0], (len + TC + 2 >= e[31:0] &&
					len <= e[31:0] + TC + 2) ? e[31:0] : len);
			end
		end
	end
	// hang guard, well above the expected run length
	initial begin
		#2000000;
		num_errors++;
		finish_test();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(hprc_pkg::REG_CFG, 8'h00);
		rd(hprc_pkg::REG_PULSE, hprc_pkg::PULSE_RESET);
		rd(4'hF, 8'h00);
		wr(hprc_pkg::REG_STATUS, 8'hFF);
		rd(hprc_pkg::REG_STATUS, 8'h00);
		pw = 8'(10 + ($random(seed) & 31));
		pol = 2'($random(seed));
		wr(hprc_pkg::REG_PULSE, pw);
		rd(hprc_pkg::REG_PULSE, pw);
		// blanking follows sense only while enabled
		wr(hprc_pkg::REG_CFG, {2'h0, pol, 4'h8});
		repeat (3) @(posedge clk_i);
		check("blank", 1, disp_blank_o);
		pwr_sense_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		check("blank", 0, disp_blank_o);
		// power on disabled while the other functions are on
		wr(hprc_pkg::REG_CFG, {2'h0, pol, 4'hE});
		pwr_sense_i <= 1'b0;
		hold(0, 40);
		settle();
		// power on: early release, then a full hold
		wr(hprc_pkg::REG_CFG, {2'h0, pol, 4'h1});
		hold(0, 20);
		settle();
		expp(1'b0, pol[0], int'(pw));
		hold(0, 30);
		settle();
		// hard off: early release, least pulse, capped extension
		pwr_sense_i <= 1'b1;
		wr(hprc_pkg::REG_CFG, {2'h0, pol, 4'h2});
		hold(1, 300);
		settle();
		// watchdog raised during the off pulse waits for the line, then runs
		expp(1'b0, pol[0], int'(pw));
		expp(1'b1, pol[1], 100);
		fork
			hold(1, 405);
			begin
				repeat (1610) @(posedge clk_i);
				wdog_req_i <= 1'b1;
				@(posedge clk_i);
				wdog_req_i <= 1'b0;
			end
		join
		settle();
		// cancel let go during the extension ends the drive at once
		expp(1'b0, pol[0], int'(pw) + 55);
		hold(1, int'(pw) + 455);
		settle();
		expp(1'b0, pol[0], int'(pw) + 500);
		hold(1, 1000 + int'(pw));
		settle();
		// hard reset by key, then by watchdog
		wr(hprc_pkg::REG_CFG, {2'h0, pol, 4'h4});
		r0 = restarts;
		expp(1'b1, pol[1], 100);
		hold(0, 410);
		settle();
		check("restart", r0 + 1, restarts);
		expp(1'b1, pol[1], 100);
		@(posedge clk_i);
		wdog_req_i <= 1'b1;
		@(posedge clk_i);
		wdog_req_i <= 1'b0;
		settle();
		check("restart", r0 + 1, restarts);
		finish_test();
	end
endmodule : test_hprc_top
